//--- pwa_pkg.sv
package pwa_pkg;

  // =====================================================================
  // Register map
  // =====================================================================
  localparam logic [11:0] ADDR_ACTIONS = 12'h060;
  localparam logic [11:0] ADDR_STATUS = 12'h070;
  localparam logic [31:0] ACTIONS_RESET = 32'h0000_0000;
  localparam logic [31:0] ACTIONS_WMASK = 32'h0000_0FFF;

  // =====================================================================
  // Field positions (low bit of each 2-bit action field, and the output bit of the status word)
  // =====================================================================
  localparam int ZERO_POS = 0;
  localparam int LOAD_POS = 2;
  localparam int CMP_A_UP_POS = 4;
  localparam int CMP_A_DOWN_POS = 6;
  localparam int CMP_B_UP_POS = 8;
  localparam int CMP_B_DOWN_POS = 10;
  localparam int STATUS_OUT_POS = 0;

  localparam logic OUT_RESET = 1'b0;
  localparam logic MODE_UP_DOWN = 1'b1;

  // =====================================================================
  // Action codes
  // =====================================================================
  typedef enum logic [1:0] {
    ACT_HOLD = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_SET = 2'h3
  } pwa_action_type;

  typedef struct packed {
    logic zero;
    logic load;
    logic cmp_a;
    logic cmp_b;
    logic count_up;
  } pwa_events_type;

endpackage

//--- pwa_action_apply.sv
`timescale 1ns/10ps
module pwa_action_apply (
  input wire logic [1:0] action_i,
  input wire logic current_i,
  output logic next_o
);

  always_comb begin
    unique case (pwa_pkg::pwa_action_type'(action_i))
      pwa_pkg::ACT_HOLD: next_o = current_i;
      pwa_pkg::ACT_TOGGLE: next_o = ~current_i;
      pwa_pkg::ACT_CLEAR: next_o = 1'b0;
      pwa_pkg::ACT_SET: next_o = 1'b1;
    endcase
  end

endmodule // pwa_action_apply

//--- pwa_output_a.sv
// Operation
// - Compare B match counting up applies field 9:8.
// - Compare B up event only in up/down mode.
// - Compare A match counting down applies field 7:6.
// - Compare A match counting up applies field 5:4.
// - Compare A up event only in up/down mode.
// - Counter equal to load applies field 3:2.
// - Counter at zero applies field 1:0.
// - Code 0 holds output, code 1 toggles it.
// - Code 2 drives output low, code 3 drives high.
// - Zero or load event beats any compare event.
// - Compare A beats compare B for output A.
// - Down-only mode: four events; up/down mode: all six.
`timescale 1ns/10ps
module pwa_output_a (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic mode_up_down_i,
  input wire logic count_up_i,
  input wire logic zero_match_i,
  input wire logic load_match_i,
  input wire logic cmp_a_match_i,
  input wire logic cmp_b_match_i,
  output logic generator_output_a_o
);

  // =====================================================================
  // Field access
  // =====================================================================
  function automatic logic [1:0] field_at(input logic [31:0] reg_value, input int pos);
    field_at = reg_value[pos +: 2];
  endfunction

  // Address decode shared by the read path and the write strobe
  function automatic logic hits_actions(input logic [11:0] addr);
    hits_actions = (addr == pwa_pkg::ADDR_ACTIONS);
  endfunction

  function automatic logic hits_status(input logic [11:0] addr);
    hits_status = (addr == pwa_pkg::ADDR_STATUS);
  endfunction

  // Only the live output level, every other bit reads zero
  function automatic logic [31:0] status_word(input logic level);
    status_word = 32'h0000_0000;
    status_word[pwa_pkg::STATUS_OUT_POS] = level;
  endfunction

  // =====================================================================
  // State
  // =====================================================================
  logic [31:0] output_a_event_actions;
  logic [31:0] next_output_a_event_actions;
  logic out_a;
  logic next_out_a;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic pready;
  logic next_pready;
  logic pslverr;
  logic next_pslverr;
  pwa_pkg::pwa_events_type ev;
  logic [1:0] chosen_action;
  logic event_hit;
  logic applied;
  logic mode_is_up_down;
  logic zero_event;
  logic load_event;
  logic cmp_a_down_event;
  logic cmp_a_up_event;
  logic cmp_a_seen;
  logic cmp_b_down_event;
  logic cmp_b_up_event;
  logic setup_phase;
  logic access_done;
  logic write_strobe;
  logic [31:0] read_word;
  logic read_error;

  assign ev = '{
    zero: zero_match_i,
    load: load_match_i,
    cmp_a: cmp_a_match_i,
    cmp_b: cmp_b_match_i,
    count_up: count_up_i
  };

  // =====================================================================
  // Event qualification
  // =====================================================================
  assign mode_is_up_down = (mode_up_down_i == pwa_pkg::MODE_UP_DOWN);
  assign zero_event = ev.zero;
  assign load_event = ev.load;
  assign cmp_a_down_event = ev.cmp_a && !ev.count_up;
  // Up-count matches exist only in up/down mode
  assign cmp_a_up_event = ev.cmp_a && ev.count_up && mode_is_up_down;
  assign cmp_b_down_event = ev.cmp_b && !ev.count_up;
  assign cmp_b_up_event = ev.cmp_b && ev.count_up && mode_is_up_down;
  // A raw compare A match masks compare B even when it is no event itself
  assign cmp_a_seen = ev.cmp_a;

  // =====================================================================
  // Event selection
  // =====================================================================
  // Zero and load never coincide in practice; zero checked first.
  always_comb begin
    chosen_action = pwa_pkg::ACT_HOLD;
    event_hit = 1'b1;
    if (zero_event) begin
      chosen_action = field_at(output_a_event_actions, pwa_pkg::ZERO_POS);
    end else if (load_event) begin
      chosen_action = field_at(output_a_event_actions, pwa_pkg::LOAD_POS);
    end else if (cmp_a_down_event) begin
      chosen_action = field_at(output_a_event_actions, pwa_pkg::CMP_A_DOWN_POS);
    end else if (cmp_a_up_event) begin
      chosen_action = field_at(output_a_event_actions, pwa_pkg::CMP_A_UP_POS);
    end else if (cmp_a_seen) begin
      // Up-count compare A outside up/down mode is no event, and still masks B
      event_hit = 1'b0;
    end else if (cmp_b_down_event) begin
      chosen_action = field_at(output_a_event_actions, pwa_pkg::CMP_B_DOWN_POS);
    end else if (cmp_b_up_event) begin
      chosen_action = field_at(output_a_event_actions, pwa_pkg::CMP_B_UP_POS);
    end else begin
      event_hit = 1'b0;
    end
  end

  pwa_action_apply u_apply (
    .action_i(chosen_action),
    .current_i(out_a),
    .next_o(applied)
  );

  always_comb begin
    next_out_a = event_hit ? applied : out_a;
    if (!nrst_i) begin
      next_out_a = pwa_pkg::OUT_RESET;
    end
  end

  always_ff @(posedge mclk_i) begin
    out_a <= next_out_a;
  end

  // =====================================================================
  // APB slave, zero wait states
  // =====================================================================
  // Ready is raised from the setup cycle, so every access phase lasts one cycle
  assign setup_phase = psel_i && !penable_i;
  assign access_done = psel_i && penable_i && pready;
  // Writes land only at the completing edge, never in the setup cycle
  assign write_strobe = access_done && pwrite_i && hits_actions(paddr_i);

  always_comb begin
    read_word = 32'h0000_0000;
    read_error = 1'b0;
    if (hits_actions(paddr_i)) begin
      read_word = output_a_event_actions;
    end else if (hits_status(paddr_i)) begin
      read_word = status_word(out_a);
    end else begin
      read_error = 1'b1;
    end
  end

  always_comb begin
    next_output_a_event_actions = output_a_event_actions;
    if (write_strobe) begin
      // Reserved bits are never stored, so they always read back zero
      next_output_a_event_actions = pwdata_i & pwa_pkg::ACTIONS_WMASK;
    end
    if (!nrst_i) begin
      next_output_a_event_actions = pwa_pkg::ACTIONS_RESET;
    end
  end

  always_ff @(posedge mclk_i) begin
    output_a_event_actions <= next_output_a_event_actions;
  end

  always_comb begin
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (setup_phase) begin
      next_pready = 1'b1;
      next_prdata = read_word;
      next_pslverr = read_error;
    end
    if (!nrst_i) begin
      next_prdata = 32'h0000_0000;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    prdata <= next_prdata;
    pready <= next_pready;
    pslverr <= next_pslverr;
  end

  // =====================================================================
  // Outputs, each straight from its flip-flop
  // =====================================================================
  assign prdata_o = prdata;
  assign pready_o = pready;
  assign pslverr_o = pslverr;
  assign generator_output_a_o = out_a;

endmodule // pwa_output_a

//--- pwa_output_a_assertions.sv
`timescale 1ns/10ps
module pwa_output_a_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic mode_up_down_i,
  input wire logic count_up_i,
  input wire logic zero_match_i,
  input wire logic load_match_i,
  input wire logic cmp_a_match_i,
  input wire logic cmp_b_match_i,
  input wire logic generator_output_a_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ==========
  // Shadow of the action word, updated on the same edge as the design
  logic [11:0] act;
  wire y = generator_output_a_o;
  wire z = zero_match_i;
  wire zl = zero_match_i || load_match_i;
  wire ca = cmp_a_match_i;
  wire cb = cmp_b_match_i;
  wire up = count_up_i;
  wire md = mode_up_down_i;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) act <= 12'h000;
    else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == pwa_pkg::ADDR_ACTIONS)
      act <= pwdata_i[11:0];
  end
  a_zero_set: assert property (z && act[1:0] == 2'h3 |=> y)
    else $error("zero event did not set output A");
  a_zero_toggle: assert property (z && act[1:0] == 2'h1 |=> y != $past(y))
    else $error("zero event did not toggle output A");
  a_load_wins: assert property (!z && zl && act[3:2] == 2'h2 |=> !y)
    else $error("load event did not clear output A");
  a_idle_hold: assert property (!(zl || ca || cb) |=> $stable(y))
    else $error("output A moved without an event");
  a_cmpa_down: assert property (!zl && ca && !up && act[7:6] == 2'h3 |=> y)
    else $error("compare A down did not set output A");
  a_cmpa_up: assert property (!zl && ca && up && md && act[5:4] == 2'h2 |=> !y)
    else $error("compare A up did not clear output A");
  a_cmpa_masks_b: assert property (!zl && ca && up && !md |=> $stable(y))
    else $error("compare A up outside up/down mode changed output A");
  a_cmpb_up: assert property (!zl && !ca && cb && up && md && act[9:8] == 2'h3 |=> y)
    else $error("compare B up did not set output A");
  a_cmpb_down: assert property (!zl && !ca && cb && !up && act[11:10] == 2'h2 |=> !y)
    else $error("compare B down did not clear output A");
  a_cmpb_nomode: assert property (!zl && !ca && cb && up && !md |=> $stable(y))
    else $error("compare B up outside up/down mode changed output A");
endmodule // pwa_output_a_checker
bind pwa_output_a pwa_output_a_checker i_chk (
  .mclk_i(mclk_i),
  .nrst_i(nrst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pready_o(pready_o),
  .mode_up_down_i(mode_up_down_i),
  .count_up_i(count_up_i),
  .zero_match_i(zero_match_i),
  .load_match_i(load_match_i),
  .cmp_a_match_i(cmp_a_match_i),
  .cmp_b_match_i(cmp_b_match_i),
  .generator_output_a_o(generator_output_a_o)
);

//--- pwa_output_a_bench.sv
`timescale 1ns/10ps
module pwa_output_a_bench;
  logic mclk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, y, err, exp_y = 0;
  logic [11:0] paddr_i = 12'h000, act = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o;
  logic [5:0] ev = 6'h00;
  int failures = 0, samples_checked = 0, seed = 6885;
  pwa_output_a i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mode_up_down_i(ev[5]), .count_up_i(ev[4]),
    .zero_match_i(ev[3]), .load_match_i(ev[2]), .cmp_a_match_i(ev[1]), .cmp_b_match_i(ev[0]),
    .generator_output_a_o(y));
  initial forever #4 mclk_i = ~mclk_i;
  // ==========
  // Priority: zero, load, compare A, compare B
  function automatic logic apply(logic [11:0] f, logic [5:0] e, logic o);
    logic [1:0] c;
    c = e[3] ? f[1:0] : e[2] ? f[3:2] : e[1] ? (e[4] ? (e[5] ? f[5:4] : 2'h0) : f[7:6])
      : e[0] ? (e[4] ? (e[5] ? f[9:8] : 2'h0) : f[11:10]) : 2'h0;
    return c == 2'h0 ? o : c == 2'h1 ? !o : c[0];
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // Request stands until ready is seen high at a rising edge; watchdog ends a hang
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge so a following call never re-drives psel in the same step
    @(posedge mclk_i);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1;
    @(posedge mclk_i);
    apb(0, pwa_pkg::ADDR_ACTIONS, 32'h0);
    check(rd, 32'h0);
    check({31'h0, y}, 32'h0);
    apb(0, 12'h0FC, 32'h0);
    check({31'h0, err}, 32'h1);
    repeat (400) begin
      if ($random(seed) % 8 == 0) begin
        act = 12'($random(seed));
        // Reserved bits written as ones must read back as zero
        apb(1, pwa_pkg::ADDR_ACTIONS, {20'hFFFFF, act});
        apb(0, pwa_pkg::ADDR_ACTIONS, 32'h0);
        check(rd, {20'h0, act});
      end
      // Back-to-back events; y seen at an edge still holds the previous result
      repeat (8) begin
        ev <= 6'($random(seed));
        @(posedge mclk_i);
        check({31'h0, y}, {31'h0, exp_y});
        exp_y = apply(act, ev, exp_y);
      end
      ev <= 6'h00;
      @(posedge mclk_i);
      check({31'h0, y}, {31'h0, exp_y});
    end
    apb(0, pwa_pkg::ADDR_STATUS, 32'h0);
    check(rd, {31'h0, exp_y});
    // Corner: drive output A high, then reset in mid-run
    apb(1, pwa_pkg::ADDR_ACTIONS, 32'h0000_0003);
    ev <= 6'h08;
    @(posedge mclk_i);
    ev <= 6'h00;
    @(posedge mclk_i);
    check({31'h0, y}, 32'h1);
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    check({31'h0, y}, 32'h0);
    apb(0, pwa_pkg::ADDR_ACTIONS, 32'h0);
    check(rd, 32'h0);
    tally_and_finish();
  end
endmodule // pwa_output_a_bench
